//--- common/port_b_pkg.sv
package port_b_pkg;

  localparam int port_width = 8;
  localparam int shared_pins = 4;
  localparam int compare_pin = 4;
  localparam int analog_channel_pin = 4;

  // Byte addresses on APB (data register at 0x0001 is an index: byte address is 4x)
  localparam logic [11:0] data_reg_index = 12'h0001;
  localparam logic [11:0] data_reg_addr = 12'h0004;
  localparam logic [11:0] direction_reg_addr = 12'h0014;
  localparam logic [11:0] pulldown_inhibit_reg_addr = 12'h0018;
  localparam logic [11:0] timer_control_reg_addr = 12'h001C;

  localparam logic [7:0] direction_reset = 8'h00;
  localparam logic [7:0] pulldown_inhibit_reset = 8'h00;
  localparam logic [7:0] data_latch_init = 8'h00;
  localparam logic timer_level_reset = 1'b0;
  localparam int timer_level_bit = 0;
  localparam logic [31:0] undefined_read = 32'h0000_0000;
  localparam logic [31:0] zero_word = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] drive_en;
    logic [7:0] pulldown_en;
  } pin_drive_s;

  typedef struct packed {
    logic comparator1_out;
    logic comparator1_out_enable;
    logic comparator_option;
    logic pulldown_option_off;
  } analog_ctrl_s;

endpackage : port_b_pkg

//--- verilog/port_b_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module port_b_pin_cell (
  // Control
  input wire logic dir,
  input wire logic pulldown_off,
  input wire logic option_off,
  input wire logic drive_value,
  // Pin
  input wire logic pin_in,
  // Result
  output logic pin_oe,
  output logic pin_out,
  output logic pulldown_en,
  output logic read_value
);

  assign pin_oe = dir;
  assign pin_out = drive_value;
  // Output mode always kills the pulldown; option overrides inhibit bit
  assign pulldown_en = ~dir & ~pulldown_off & ~option_off;
  assign read_value = dir ? drive_value : pin_in;

endmodule : port_b_pin_cell

`default_nettype wire

//--- verilog/port_b_read_mux.sv
`timescale 1ns/1ps
`default_nettype none

module port_b_read_mux
  import port_b_pkg::*;
(
  // Select
  input wire logic [11:0] addr,
  // Sources
  input wire logic [7:0] port_value,
  input wire logic [7:0] direction,
  input wire logic timer_level,
  // Result
  output logic [31:0] rdata,
  output logic slverr
);

  always_comb begin
    rdata = zero_word;
    slverr = 1'b0;
    case (addr)
      data_reg_addr: rdata = {24'h00_0000, port_value};
      direction_reg_addr: rdata = {24'h00_0000, direction};
      // Write-only: fixed pattern, no side effect on stored bits
      pulldown_inhibit_reg_addr: rdata = undefined_read;
      timer_control_reg_addr: rdata = {31'h0000_0000, timer_level};
      default: slverr = 1'b1;
    endcase
  end

endmodule : port_b_read_mux

`default_nettype wire

//--- verilog/port_b_pulldown_pin_logic.sv
// Summary of operation
// R1 - Pulldown inhibit register is write-only; reads return junk, no side effect.
// R2 - Reset clears all eight inhibit bits, pulldowns on for inputs.
// R3 - Inhibit bit 1 turns pulldown off; 0 enables it only on inputs.
// R4 - Pulldown option input forces all pulldowns off regardless of bits.
// R5 - Output direction drives pin from latch and disables pulldown.
// R6 - Reading an output bit returns data latch value.
// R7 - Reading an input bit returns digital pin level, analog too.
// R8 - Data latch writes always take effect regardless of direction.
// R9 - Lower four pins feed another module; pulldown loads it too.
// R10 - Direction register always readable and writable.
// R11 - Fifth pin drives OR of latch, timer level, gated comparator.
// R12 - Comparator term needs output 1, enable 1 and option enabled.
// R13 - Fifth pin output high by timer or comparator reads back 1.
// R14 - Software clears timer level and option for data-only drive.
// R15 - Software clears data bit and option for timer drive.
// R16 - Fifth pin feeds analog channel 4; input reads binary.
// R17 - Direction 1 enables output, 0 input; reset clears direction.
// R18 - Reset leaves data latches; data register at index 0x0001.
// R19 - Bus writes land on completing edge; pins follow next cycle.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module port_b_pulldown_pin_logic
  import port_b_pkg::*;
#(
  parameter int width = port_width
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog and option controls
  input wire port_b_pkg::analog_ctrl_s analog_ctrl,
  // Port pins
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe,
  output logic [7:0] pulldown_en,
  // Alternate taps
  output logic [3:0] shared_module_in,
  output logic analog_in_ch4,
  output logic timer_compare_pin,
  output port_b_pkg::pin_drive_s pin_drive
);
  import port_b_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_en;
  logic [7:0] data_latch_r;
  logic [7:0] direction_reg_r;
  logic [7:0] pulldown_inhibit_reg_r;
  logic timer_control_reg_r;
  logic [7:0] read_value;
  logic [7:0] drive_value;
  logic [7:0] pin_oe_c;
  logic [7:0] pin_out_c;
  logic [7:0] pd_c;
  logic [31:0] rdata_c;
  logic slverr_c;
  logic comparator_term;

  // Zero-wait slave; every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & pstrb[0]; // R19

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // No reset: port data survives reset
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == data_reg_addr) begin
      data_latch_r <= pwdata[7:0]; // R8 R18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_reg_r <= direction_reset; // R17
    end else if (wr_en && paddr == direction_reg_addr) begin
      direction_reg_r <= pwdata[7:0]; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulldown_inhibit_reg_r <= pulldown_inhibit_reset; // R2
    end else if (wr_en && paddr == pulldown_inhibit_reg_addr) begin
      pulldown_inhibit_reg_r <= pwdata[7:0]; // R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg_r <= timer_level_reset;
    end else if (wr_en && paddr == timer_control_reg_addr) begin
      timer_control_reg_r <= pwdata[timer_level_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin logic

  assign comparator_term = analog_ctrl.comparator1_out & analog_ctrl.comparator1_out_enable
                           & analog_ctrl.comparator_option; // R12

  always_comb begin
    drive_value = data_latch_r;
    // OR of the three sources; reads back the OR so a forced high shows as 1
    drive_value[compare_pin] = data_latch_r[compare_pin] | timer_control_reg_r
                               | comparator_term; // R11 R13
  end

  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_pin
      port_b_pin_cell u_cell (
        .dir(direction_reg_r[i]),
        .pulldown_off(pulldown_inhibit_reg_r[i]),
        .option_off(analog_ctrl.pulldown_option_off), // R4
        .drive_value(drive_value[i]), // R5
        .pin_in(port_pin_in[i]), // R7
        .pin_oe(pin_oe_c[i]),
        .pin_out(pin_out_c[i]),
        .pulldown_en(pd_c[i]),
        .read_value(read_value[i]) // R6
      );
    end
  endgenerate

  // Registered pin drive: visible the cycle after the write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_oe <= direction_reset;
      port_pin_out <= data_latch_init;
      pulldown_en <= ~pulldown_inhibit_reset;
    end else begin
      port_pin_oe <= pin_oe_c; // R17 R19
      port_pin_out <= pin_out_c; // R5
      pulldown_en <= pd_c; // R3 R9
    end
  end

  assign pin_drive.data_out = port_pin_out;
  assign pin_drive.drive_en = port_pin_oe;
  assign pin_drive.pulldown_en = pulldown_en;

  // Pins feed other modules directly, whatever the direction
  assign shared_module_in = port_pin_in[shared_pins-1:0]; // R9
  assign analog_in_ch4 = port_pin_in[analog_channel_pin]; // R16
  assign timer_compare_pin = port_pin_out[compare_pin];

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  port_b_read_mux u_rmux (
    .addr(paddr),
    .port_value(read_value), // R16
    .direction(direction_reg_r), // R10
    .timer_level(timer_control_reg_r),
    .rdata(rdata_c), // R1
    .slverr(slverr_c)
  );

  always_comb begin
    prdata = zero_word;
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = slverr_c;
      if (!pwrite) begin
        prdata = rdata_c;
      end
    end
  end

endmodule : port_b_pulldown_pin_logic

`default_nettype wire

//--- testbench/port_b_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

module port_b_pins_model (
  // Device side
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic [7:0] pulldown_en,
  // Far side
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  // Floating line: invert the latch so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_pin_oe[i]) level[i] = port_pin_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else level[i] = pulldown_en[i] ? 1'b0 : ~port_pin_out[i];
    end
  end
endmodule : port_b_pins_model
`default_nettype wire

//--- testbench/port_b_pulldown_pin_logic_chk.sv
`timescale 1ns/1ps
`default_nettype none

module port_b_chk
  import port_b_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  // Pins
  input wire port_b_pkg::analog_ctrl_s analog_ctrl,
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic [7:0] pulldown_en,
  input wire logic [3:0] shared_module_in,
  input wire logic analog_in_ch4,
  input wire logic timer_compare_pin,
  input wire port_b_pkg::pin_drive_s pin_drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence dir_wr;
    psel && penable && pwrite && pstrb[0] && paddr == direction_reg_addr;
  endsequence
  a_reset_state: assert property (
    $rose(presetn) |-> port_pin_oe == 8'h00 && pulldown_en == 8'hFF)
    else $error("reset state wrong");
  a_dir_lands: assert property (
    dir_wr |=> ##1 port_pin_oe == $past(pwdata[7:0], 2))
    else $error("direction not applied");
  a_pd_vs_oe: assert property ((port_pin_oe & pulldown_en) == 8'h00)
    else $error("pulldown on an output");
  a_option_off: assert property (
    $past(presetn) && $past(analog_ctrl.pulldown_option_off) |-> pulldown_en == 8'h00)
    else $error("option did not force pulldowns off");
  a_cmp_drive: assert property (
    $past(presetn) && $past(analog_ctrl[3:1]) == 3'b111 |-> port_pin_out[4])
    else $error("comparator term lost");
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  a_taps_follow: assert property (
    shared_module_in == port_pin_in[3:0] && analog_in_ch4 == port_pin_in[4])
    else $error("tap mismatch");
  a_copies_match: assert property (
    timer_compare_pin == port_pin_out[4] && pin_drive == {port_pin_out, port_pin_oe, pulldown_en})
    else $error("copy mismatch");
endmodule : port_b_chk

bind port_b_pulldown_pin_logic port_b_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .analog_ctrl, .port_pin_in, .port_pin_out, .port_pin_oe,
  .pulldown_en, .shared_module_in, .analog_in_ch4, .timer_compare_pin, .pin_drive);
`default_nettype wire

//--- testbench/port_b_pulldown_pin_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none

module port_b_pulldown_pin_logic_tb;
  import port_b_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  analog_ctrl_s actl = '0;
  logic [7:0] pin, out, oe, pd, ext_en = 0, ext_val = 0;
  logic [3:0] shared;
  logic [2:0] cm [4] = '{3'b111, 3'b011, 3'b101, 3'b110};
  int num_errors = 0, cmp_count = 0;
  always #5 pclk = ~pclk;
  port_b_pulldown_pin_logic uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .analog_ctrl(actl), .port_pin_in(pin),
    .port_pin_out(out), .port_pin_oe(oe), .pulldown_en(pd), .shared_module_in(shared),
    .analog_in_ch4(), .timer_compare_pin(), .pin_drive());
  port_b_pins_model ext (.port_pin_out(out), .port_pin_oe(oe), .pulldown_en(pd), .ext_en,
    .ext_val, .level(pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Outputs lag a write by one edge; look at them mid-cycle
  task automatic settle;
    @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // Latch has no reset; load it under reset so pins never go unknown
    repeat (6) @(posedge pclk);
    apb(data_reg_addr, 1'b1, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(oe, 8'h00);
    chk(pd, 8'hFF);
    apb(direction_reg_addr, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    apb(pulldown_inhibit_reg_addr, 1'b1, 32'h0000_00A5);
    settle();
    chk(pd, 8'h5A);
    apb(pulldown_inhibit_reg_addr, 1'b0, 32'h0000_0000);
    chk(err, 1'b0);
    settle();
    chk(pd, 8'h5A);
    @(posedge pclk);
    actl.pulldown_option_off <= 1'b1;
    settle();
    chk(pd, 8'h00);
    @(posedge pclk);
    actl.pulldown_option_off <= 1'b0;
    settle();
    chk(pd, 8'h5A);
    $display("pulldown test done");
    apb(data_reg_addr, 1'b1, 32'h0000_000F);
    apb(direction_reg_addr, 1'b1, 32'h0000_001F);
    settle();
    chk(oe, 8'h1F);
    chk(out[4:0], 5'h0F);
    chk(pd, 8'h40);
    apb(direction_reg_addr, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_001F);
    $display("direction test done");
    apb(timer_control_reg_addr, 1'b1, 32'h0000_0001);
    settle();
    chk(out[4], 1'b1);
    apb(data_reg_addr, 1'b0, 32'h0000_0000);
    chk(rd[4], 1'b1);
    apb(timer_control_reg_addr, 1'b1, 32'h0000_0000);
    foreach (cm[i]) begin
      @(posedge pclk);
      actl <= {cm[i], 1'b0};
      settle();
      chk(out[4], i == 0);
    end
    $display("pin4 test done");
    @(posedge pclk);
    ext_en <= 8'hF0;
    ext_val <= 8'h50;
    apb(direction_reg_addr, 1'b1, 32'h0000_000F);
    settle();
    apb(data_reg_addr, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_005F);
    chk(shared, 4'hF);
    $display("read test done");
    apb(12'h0008, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(oe, 8'h00);
    chk(pd, 8'hFF);
    apb(direction_reg_addr, 1'b1, 32'h0000_00FF);
    apb(data_reg_addr, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_000F);
    $display("second reset test done");
    print_verdict();
  end
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule : port_b_pulldown_pin_logic_tb
`default_nettype wire
